//--- rtl/tws_regs.vh
// register indices, field positions, codes and reset values of the two-wire unit
// assumes a 32-bit bus where a register's byte address is four times its index
`ifndef TWS_REGS_VH
`define TWS_REGS_VH

// register indices; byte address is index times four
`define TWS_IDX_CTRL 8'h93
`define TWS_IDX_STATUS 8'h94
`define TWS_IDX_DATA 8'h95
`define TWS_IDX_OWN 8'h96
`define TWS_IDX_IRQ_STAT 8'h97
`define TWS_IDX_IRQ_MASK 8'h98

// control register fields
`define TWS_CTRL_EN 6
`define TWS_CTRL_FLAG 3
`define TWS_CTRL_ACK 2

// own address register fields
`define TWS_OWN_GEN_EN 0

// interrupt status / mask fields
`define TWS_IRQ_NEWCODE 0
`define TWS_IRQ_STOP 1

// five-bit status codes (register shows them in bits 7..3)
`define TWS_SC_IDLE 5'h1F
`define TWS_SC_OWN_W 5'h0C
`define TWS_SC_GEN_CALL 5'h0E
`define TWS_SC_RX_ACK 5'h10
`define TWS_SC_RX_NACK 5'h11
`define TWS_SC_STOP 5'h14
`define TWS_SC_OWN_R 5'h15
`define TWS_SC_TX_ACK 5'h17
`define TWS_SC_TX_NACK 5'h18

// reset values and the general call address
`define TWS_RST_BYTE 8'h00
`define TWS_RST_MASK 2'h0
`define TWS_GEN_CALL_ADDR 7'h00

`endif

//--- rtl/tws_unit.v
// two-wire slave unit: data, status, own-address registers and the slave bit engine
// assumes scl_in/sda_in already synchronous to clk; pins are open drain, driven low only
//
// Summary of operation
// [R1] data register holds the byte to send or the last byte received
// [R2] in an address byte bit 0 is direction, bits 7..1 the target address
// [R3] status register reads code in bits 7..3, zeros in bits 2..0
// [R4] own-address register bits 7..1 hold the address the slave answers to
// [R5] own-address bit 0 enables general call recognition
// [R6] flag set on each new status code; software clears it to let transfer proceed
// [R7] acknowledge control set drives low acknowledge; cleared leaves line high
// [R8] received address matched against own address or enabled general call
`timescale 1ns/1ns
`include "tws_regs.vh"

module tws_unit (
    input wire clk,
    input wire rst,
    input wire [9:0] address,
    input wire read,
    input wire write,
    input wire [31:0] writedata,
    input wire [3:0] byteenable,
    output reg [31:0] readdata,
    output reg waitrequest,
    input wire scl_in,
    output reg scl_out,
    output reg scl_oe,
    input wire sda_in,
    output reg sda_out,
    output reg sda_oe,
    output reg irq
);
localparam S_IDLE = 3'd0;
localparam S_ADDR = 3'd1;
localparam S_AACK = 3'd2;
localparam S_RX = 3'd3;
localparam S_RACK = 3'd4;
localparam S_TX = 3'd5;
localparam S_TACK = 3'd6;
reg [2:0] state_q;
reg [3:0] cnt_q;
reg [7:0] shift_q;
reg [7:0] data_q;
reg [7:0] own_q;
reg [4:0] code_q;
reg en_q;
reg ack_ctl_q;
reg flag_q;
reg rw_q;
reg gen_hit_q;
reg ack_q;
reg txl_q;
reg [1:0] irq_stat_q;
reg [1:0] irq_mask_q;
reg scl_prev_q;
reg sda_prev_q;
wire req = read | write;
wire acc = req & ~waitrequest;
wire [7:0] idx = address[9:2];
wire wr_ctrl = acc & write & byteenable[0] & (idx == `TWS_IDX_CTRL);
wire wr_data = acc & write & byteenable[0] & (idx == `TWS_IDX_DATA);
wire wr_own = acc & write & byteenable[0] & (idx == `TWS_IDX_OWN);
wire wr_istat = acc & write & byteenable[0] & (idx == `TWS_IDX_IRQ_STAT);
wire wr_imask = acc & write & byteenable[0] & (idx == `TWS_IDX_IRQ_MASK);
// bus line events
wire scl_rise = scl_in & ~scl_prev_q;
wire scl_fall = ~scl_in & scl_prev_q;
wire start_c = scl_in & scl_prev_q & sda_prev_q & ~sda_in;
wire stop_c = scl_in & scl_prev_q & ~sda_prev_q & sda_in;
wire addressed = (state_q != S_IDLE) && (state_q != S_ADDR);
// address compare against own address and general call
wire own_hit = shift_q[7:1] == own_q[7:1]; // [R8] [R4]
wire gen_hit = own_q[`TWS_OWN_GEN_EN] & (shift_q[7:1] == `TWS_GEN_CALL_ADDR) & ~shift_q[0]; // [R5]
// engine event strobes feeding flag and interrupt status
reg new_code;
reg stop_evt;
reg [4:0] code_d;
// avalon slave: one wait cycle, then the access completes
always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        waitrequest <= 1'b1;
        readdata <= 32'h00000000;
    end
    else
    begin
        waitrequest <= ~(req & waitrequest);
        if (req & waitrequest)
        begin
            case (idx)
                `TWS_IDX_CTRL: readdata <= {24'h000000, 1'b0, en_q, 2'b00, flag_q, ack_ctl_q, 2'b00};
                `TWS_IDX_STATUS: readdata <= {24'h000000, code_q, 3'b000}; // [R3]
                `TWS_IDX_DATA: readdata <= {24'h000000, data_q}; // [R1]
                `TWS_IDX_OWN: readdata <= {24'h000000, own_q}; // [R4] [R5]
                `TWS_IDX_IRQ_STAT: readdata <= {30'h00000000, irq_stat_q};
                `TWS_IDX_IRQ_MASK: readdata <= {30'h00000000, irq_mask_q};
                default: readdata <= 32'h00000000;
            endcase
        end
    end
end
// software-owned registers; hardware set of flags wins over clears
always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        own_q <= `TWS_RST_BYTE;
        en_q <= 1'b0;
        ack_ctl_q <= 1'b0;
        flag_q <= 1'b0;
        irq_stat_q <= 2'b00;
        irq_mask_q <= `TWS_RST_MASK;
        irq <= 1'b0;
    end
    else
    begin
        if (wr_own)
            own_q <= writedata[7:0]; // [R4] [R5]
        if (wr_ctrl)
        begin
            en_q <= writedata[`TWS_CTRL_EN];
            ack_ctl_q <= writedata[`TWS_CTRL_ACK];
        end
        if (new_code)
            flag_q <= 1'b1; // [R6]
        else if (wr_ctrl & ~writedata[`TWS_CTRL_FLAG])
            flag_q <= 1'b0; // [R6]
        irq_stat_q <= (irq_stat_q & ~(wr_istat ? writedata[1:0] : 2'b00)) | {stop_evt, new_code};
        if (wr_imask)
            irq_mask_q <= writedata[1:0];
        irq <= |(irq_stat_q & irq_mask_q);
    end
end
// event and code decode for the current cycle
always @*
begin
    new_code = 1'b0;
    stop_evt = 1'b0;
    code_d = code_q;
    if (en_q & stop_c & addressed)
    begin
        stop_evt = 1'b1;
        new_code = 1'b1;
        code_d = `TWS_SC_STOP;
    end
    else if (en_q & ~start_c & ~stop_c & scl_fall)
    begin
        if (state_q == S_AACK)
        begin
            new_code = 1'b1;
            code_d = rw_q ? `TWS_SC_OWN_R : (gen_hit_q ? `TWS_SC_GEN_CALL : `TWS_SC_OWN_W);
        end
        else if (state_q == S_RACK)
        begin
            new_code = 1'b1;
            code_d = ack_q ? `TWS_SC_RX_ACK : `TWS_SC_RX_NACK;
        end
    end
    else if (en_q & ~start_c & ~stop_c & scl_rise & (state_q == S_TACK))
    begin
        new_code = 1'b1;
        code_d = sda_in ? `TWS_SC_TX_NACK : `TWS_SC_TX_ACK;
    end
end
// slave bit engine
always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        state_q <= S_IDLE;
        cnt_q <= 4'h0;
        shift_q <= `TWS_RST_BYTE;
        data_q <= `TWS_RST_BYTE;
        code_q <= `TWS_SC_IDLE;
        rw_q <= 1'b0;
        gen_hit_q <= 1'b0;
        ack_q <= 1'b0;
        txl_q <= 1'b0;
        scl_prev_q <= 1'b1;
        sda_prev_q <= 1'b1;
        sda_oe <= 1'b0;
        scl_oe <= 1'b0;
        sda_out <= 1'b0;
        scl_out <= 1'b0;
    end
    else
    begin
        scl_prev_q <= scl_in;
        sda_prev_q <= sda_in;
        code_q <= code_d;
        // hold the clock low while the flag waits for software
        scl_oe <= en_q & flag_q & addressed & (scl_oe | ~scl_in); // [R6]
        if (wr_data)
            data_q <= writedata[7:0]; // [R1]
        if (~en_q | stop_c)
        begin
            state_q <= S_IDLE;
            sda_oe <= 1'b0;
        end
        else if (start_c)
        begin
            state_q <= S_ADDR;
            cnt_q <= 4'h0;
            sda_oe <= 1'b0;
        end
        else
        begin
            case (state_q)
                S_ADDR:
                begin
                    if (scl_rise)
                    begin
                        shift_q <= {shift_q[6:0], sda_in};
                        cnt_q <= cnt_q + 4'h1;
                    end
                    else if (scl_fall && cnt_q == 4'h8)
                    begin
                        if (ack_ctl_q & (own_hit | gen_hit)) // [R8]
                        begin
                            sda_oe <= 1'b1; // [R7]
                            rw_q <= shift_q[0]; // [R2]
                            gen_hit_q <= gen_hit & ~own_hit;
                            state_q <= S_AACK;
                        end
                        else
                            state_q <= S_IDLE;
                    end
                end
                S_AACK:
                    if (scl_fall)
                    begin
                        sda_oe <= 1'b0;
                        data_q <= shift_q; // [R1] [R2]
                        cnt_q <= 4'h0;
                        txl_q <= rw_q;
                        state_q <= rw_q ? S_TX : S_RX;
                    end
                S_RX:
                    if (scl_rise)
                    begin
                        shift_q <= {shift_q[6:0], sda_in};
                        cnt_q <= cnt_q + 4'h1;
                    end
                    else if (scl_fall && cnt_q == 4'h8)
                    begin
                        sda_oe <= ack_ctl_q; // [R7]
                        ack_q <= ack_ctl_q;
                        state_q <= S_RACK;
                    end
                S_RACK:
                    if (scl_fall)
                    begin
                        sda_oe <= 1'b0;
                        data_q <= shift_q; // [R1]
                        cnt_q <= 4'h0;
                        state_q <= ack_q ? S_RX : S_IDLE;
                    end
                S_TX:
                    if (txl_q)
                    begin
                        if (~flag_q)
                        begin
                            shift_q <= data_q; // [R1]
                            sda_oe <= ~data_q[7];
                            txl_q <= 1'b0;
                        end
                    end
                    else if (scl_rise)
                        cnt_q <= cnt_q + 4'h1;
                    else if (scl_fall)
                    begin
                        if (cnt_q == 4'h8)
                        begin
                            sda_oe <= 1'b0;
                            state_q <= S_TACK;
                        end
                        else
                        begin
                            shift_q <= {shift_q[6:0], 1'b0};
                            sda_oe <= ~shift_q[6];
                        end
                    end
                S_TACK:
                    if (scl_rise)
                    begin
                        cnt_q <= 4'h0;
                        txl_q <= ~sda_in;
                        state_q <= sda_in ? S_IDLE : S_TX;
                    end
                default:
                    state_q <= S_IDLE;
            endcase
        end
    end
end
endmodule

//--- verification/tws_unit_asserts.sv
// checker of the two-wire unit: bus handshake, read data, interrupt and wire timing
// assumes binding to tws_unit and sight of its ports only
`timescale 1ns/1ns
`include "tws_regs.vh"

module tws_unit_asserts (
    input wire clk,
    input wire rst,
    input wire [9:0] address,
    input wire read,
    input wire write,
    input wire [31:0] writedata,
    input wire [31:0] readdata,
    input wire waitrequest,
    input wire scl_in,
    input wire scl_out,
    input wire scl_oe,
    input wire sda_out,
    input wire sda_oe,
    input wire irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // bus answer and read data
    a_one_wait: assert property ((read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
        else $error("no single wait cycle");
    a_idle_wait: assert property (!read && !write && waitrequest |=> waitrequest)
        else $error("answer without request");
    a_rdata_hold: assert property ($changed(readdata) |-> !waitrequest)
        else $error("read data moved");
    a_rdata_upper: assert property (read && !waitrequest |-> readdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_status_zeros: assert property (read && !waitrequest && address[9:2] == `TWS_IDX_STATUS
        |-> readdata[2:0] == 3'h0) else $error("status low bits set");
    // interrupt drops two cycles after a zero mask is written
    a_mask_off: assert property (write && !waitrequest && address[9:2] == `TWS_IDX_IRQ_MASK
        && writedata[1:0] == 2'h0 |-> ##2 !irq) else $error("masked irq high");
    // data drive moves and clock stretch begins only while the clock is low
    a_sda_scl_low: assert property ($changed(sda_oe) |-> !$past(scl_in))
        else $error("data drive moved with clock high");
    a_stretch_low: assert property ($rose(scl_oe) |-> !$past(scl_in))
        else $error("stretch began with clock high");
    // open-drain pins only ever pull low
    a_pins_low: assert property (!scl_out && !sda_out)
        else $error("pin data output driven high");
endmodule

bind tws_unit tws_unit_asserts u_chk (.clk(clk), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .scl_in(scl_in),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));

//--- verification/tws_bus_master.sv
// two-wire bus master model: start, stop, byte write and byte read
// assumes pulled-up wires; a drive output high pulls its wire low
`timescale 1ns/1ns

module tws_bus_master (
    input wire clk,
    input wire scl,
    input wire sda,
    output reg scl_drive,
    output reg sda_drive
);
    integer hp = 4;
    reg r;
    integer timeouts = 0;

    // wires released at start
    initial
    begin
        scl_drive = 1'b0;
        sda_drive = 1'b0;
    end

    // one bit: data set with clock low, sampled at end of clock high; a stretch is waited out
    task bit_xfer(input b, output q);
        integer n;
    begin
        sda_drive <= !b;
        repeat (hp) @(posedge clk);
        scl_drive <= 1'b0;
        for (n = 0; scl !== 1'b1 && n < 5000; n = n + 1)
            @(posedge clk);
        if (n == 5000)
            timeouts = timeouts + 1;
        repeat (hp) @(posedge clk);
        q = sda;
        scl_drive <= 1'b1;
    end
    endtask

    // start: data falls with clock high
    task start;
    begin
        sda_drive <= 1'b1;
        repeat (hp) @(posedge clk);
        scl_drive <= 1'b1;
    end
    endtask

    // stop: data rises with clock high
    task stop;
    begin
        sda_drive <= 1'b1;
        repeat (hp) @(posedge clk);
        scl_drive <= 1'b0;
        repeat (hp) @(posedge clk);
        sda_drive <= 1'b0;
        repeat (hp) @(posedge clk);
    end
    endtask

    // byte out msb first, bit 0 of an address is the direction; returns not-acknowledge
    task write_byte(input [7:0] b, output nack);
        integer i;
    begin
        for (i = 7; i >= 0; i = i - 1)
            bit_xfer(b[i], r);
        bit_xfer(1'b1, nack);
        repeat (hp) @(posedge clk); // clock held low while the slave posts its code
    end
    endtask

    // byte in msb first, then our acknowledge (0) or refusal (1)
    task read_byte(input nack, output [7:0] b);
        integer i;
    begin
        for (i = 7; i >= 0; i = i - 1)
        begin
            bit_xfer(1'b1, r);
            b[i] = r;
        end
        bit_xfer(nack, r);
        repeat (hp) @(posedge clk); // clock held low; the slave posted its code at the rise of the acknowledge clock
    end
    endtask
endmodule

//--- verification/tws_unit_test.sv
// bench of the two-wire unit: registers over the bus, slave transfers on the wires
// assumes the bus master model on pulled-up wires and the bound checker
`timescale 1ns/1ns
`include "tws_regs.vh"

module tws_unit_test;
    reg clk, rst, read, write, ack;
    reg [9:0] address;
    reg [31:0] writedata;
    reg [7:0] rd;
    wire [31:0] readdata;
    wire waitrequest, scl_oe, sda_oe, m_scl, m_sda, irq, scl_w, sda_w;
    integer mismatches, checked, i;

    // open-drain wires with pull-ups
    assign scl_w = !(scl_oe || m_scl);
    assign sda_w = !(sda_oe || m_sda);

    tws_unit uut (.clk(clk), .rst(rst), .address(address), .read(read), .write(write), .writedata(writedata),
        .byteenable(4'hF), .readdata(readdata), .waitrequest(waitrequest), .scl_in(scl_w), .scl_out(),
        .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(), .sda_oe(sda_oe), .irq(irq));
    tws_bus_master u_m (.clk(clk), .scl(scl_w), .sda(sda_w), .scl_drive(m_scl), .sda_drive(m_sda));

    // compare and count
    task chk(input [7:0] got, input [7:0] exp);
    begin
        checked = checked + 1;
        if (got !== exp)
        begin
            mismatches = mismatches + 1;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask

    // one bus access, held until waitrequest is sampled low at a rising edge; read data lands in rd
    task bus(input integer wr, input [7:0] idx, input [7:0] d);
        integer n;
    begin
        address <= {idx, 2'h0};
        writedata <= {24'h0, d};
        write <= (wr != 0);
        read <= (wr == 0);
        n = 0;
        @(posedge clk);
        while (waitrequest !== 1'b0 && n < 50)
        begin
            n = n + 1;
            @(posedge clk);
        end
        if (n == 50)
            mismatches = mismatches + 1;
        rd = readdata[7:0];
        write <= 1'b0;
        read <= 1'b0;
        @(posedge clk);
    end
    endtask

    // register read and compare
    task rc(input [7:0] idx, input [7:0] exp);
    begin
        bus(0, idx, 8'h00);
        chk(rd, exp);
    end
    endtask

    // interrupt level once settled
    task ic(input integer exp);
    begin
        repeat (2) @(negedge clk);
        chk({7'h0, irq}, exp[7:0]);
        @(posedge clk);
    end
    endtask

    // reset values, read-write and read-only places, unmapped place
    task t_regs;
    begin
        rc(8'h94, {`TWS_SC_IDLE, 3'h0});
        rc(8'h96, `TWS_RST_BYTE);
        bus(1, 8'h95, 8'hA5);
        rc(8'h95, 8'hA5);
        bus(1, 8'h96, 8'h55);
        rc(8'h96, 8'h55);
        bus(1, 8'h94, 8'h00);
        rc(8'h94, {`TWS_SC_IDLE, 3'h0});
        rc(8'h40, 8'h00);
    end
    endtask

    // addressed write, interrupt raise and clear, data with acknowledge on and off
    task t_write;
    begin
        bus(1, 8'h96, 8'h54);
        bus(1, 8'h98, 8'h01);
        bus(1, 8'h93, 8'h44);
        u_m.start;
        u_m.write_byte(8'h54, ack);
        chk({7'h00, ack}, 8'h00);
        rc(8'h94, {`TWS_SC_OWN_W, 3'h0});
        rc(8'h95, 8'h54);
        ic(1);
        bus(1, 8'h98, 8'h00);
        ic(0);
        bus(1, 8'h98, 8'h01);
        ic(1);
        bus(1, 8'h97, 8'h01);
        ic(0);
        bus(1, 8'h98, 8'h00);
        for (i = 0; i < 2; i = i + 1)
        begin
            bus(1, 8'h93, i ? 8'h40 : 8'h44);
            u_m.write_byte(8'h3C + i[7:0], ack);
            chk({7'h00, ack}, i[7:0]);
            rc(8'h94, {i ? `TWS_SC_RX_NACK : `TWS_SC_RX_ACK, 3'h0});
            rc(8'h95, 8'h3C + i[7:0]);
        end
        bus(1, 8'h93, 8'h44);
        u_m.stop;
    end
    endtask

    // slow master: general call on, off, then a foreign address
    task t_gcall;
    begin
        u_m.hp = 12;
        for (i = 0; i < 3; i = i + 1)
        begin
            bus(1, 8'h93, 8'h44);
            bus(1, 8'h96, {7'h2A, i == 0});
            u_m.start;
            u_m.write_byte(i == 2 ? 8'h56 : 8'h00, ack);
            chk({7'h00, ack}, {7'h00, i != 0});
            if (i == 0) rc(8'h94, {`TWS_SC_GEN_CALL, 3'h0});
            bus(1, 8'h93, 8'h44);
            u_m.stop;
            if (i == 0) rc(8'h94, {`TWS_SC_STOP, 3'h0});
        end
        u_m.hp = 4;
    end
    endtask

    // addressed read: master acknowledges one byte, refuses the next
    task t_read;
    begin
        bus(1, 8'h93, 8'h44);
        u_m.start;
        u_m.write_byte(8'h55, ack);
        chk({7'h00, ack}, 8'h00);
        rc(8'h94, {`TWS_SC_OWN_R, 3'h0});
        for (i = 0; i < 2; i = i + 1)
        begin
            bus(1, 8'h95, 8'h96 + i[7:0]);
            bus(1, 8'h93, 8'h44);
            u_m.read_byte(i[0], rd);
            chk(rd, 8'h96 + i[7:0]);
            rc(8'h94, {i ? `TWS_SC_TX_NACK : `TWS_SC_TX_ACK, 3'h0});
        end
        bus(1, 8'h93, 8'h44);
        u_m.stop;
    end
    endtask

    // counts and verdict
    task print_verdict;
    begin
        mismatches = mismatches + u_m.timeouts;
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    end
    endtask

    // clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = !clk;
    end

    // reset, scenarios, verdict
    initial
    begin
        rst = 1'b1;
        read = 1'b0;
        write = 1'b0;
        address = 10'h000;
        writedata = 32'h0;
        mismatches = 0;
        checked = 0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_regs;
        t_write;
        t_gcall;
        t_read;
        print_verdict;
    end

    // watchdog
    initial
    begin
        #400000;
        mismatches = mismatches + 1;
        print_verdict;
    end
endmodule
